/* design/prhc_regs.svh */
// How it works
// - bit7 set disables switchover deglitch
// - bit6 picks ref_in_b when bits 5 and 0 clear
// - bit5 set follows ref_choice_pin instead while bit0 clear
// - bit2 powers ref_in_b buffer
// - bit1 powers ref_in_a buffer
// - bit0 set selects differential reference mode
// - hold bit4 set blocks pll status readback
// - hold bit3 enables lock pin comparator
// - disabled comparator reads as true
// - automatic holdover needs prior lock from comparator
// - holdover only when hold bits 2,0 set
// - hold bit1 hands holdover to sync_hold_pin
// - reference bits 4:3 reserved, no effect
// - status bit5 shows holdover state active
// - status bit4 shows ref_in_b feeding pll
`ifndef PRHC_REGS_SVH
`define PRHC_REGS_SVH

// register indices, byte address is four times the index
`define PRHC_IDX_REF_CTRL 8'h1c
`define PRHC_IDX_HOLD_CTRL 8'h1d
`define PRHC_IDX_PLL_STAT 8'h1f
`define PRHC_IDX_IRQ_STAT 8'h20
`define PRHC_IDX_IRQ_MASK 8'h21

// reference_input_control fields
`define PRHC_REF_DEGLITCH_DIS 7
`define PRHC_REF_SEL_B 6
`define PRHC_REF_USE_PIN 5
`define PRHC_REF_B_PWR 2
`define PRHC_REF_A_PWR 1
`define PRHC_REF_DIFF 0
`define PRHC_REF_WMASK 8'he7
`define PRHC_REF_RESET 8'h00

// holdover_lock_control fields
`define PRHC_HOLD_STAT_DIS 4
`define PRHC_HOLD_CMP_EN 3
`define PRHC_HOLD_EN_HI 2
`define PRHC_HOLD_EXT 1
`define PRHC_HOLD_EN_LO 0
`define PRHC_HOLD_WMASK 8'h1f
`define PRHC_HOLD_RESET 8'h00

// pll status fields
`define PRHC_STAT_VCO_CAL 6
`define PRHC_STAT_HOLD 5
`define PRHC_STAT_REF_B 4
`define PRHC_STAT_VCO_OK 3
`define PRHC_STAT_REFB_OK 2
`define PRHC_STAT_REFA_OK 1
`define PRHC_STAT_LOCK 0

// interrupt status and mask fields
`define PRHC_IRQ_HOLD_IN 0
`define PRHC_IRQ_HOLD_OUT 1
`define PRHC_IRQ_REF_SW 2
`define PRHC_IRQ_LOCK_LOST 3
`define PRHC_IRQ_RESET 4'h0

// timing: deglitch gap in ns, clock rate in MHz, gap rounded up to cycles
`define PRHC_DEGLITCH_NS 20
`define PRHC_CLK_MHZ 250
`define PRHC_DEGLITCH_CYC ((`PRHC_DEGLITCH_NS * `PRHC_CLK_MHZ + 999) / 1000)

`endif

/* design/prhc_pkg.sv */
package prhc_pkg;

    // one register access, pulsed for a single cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] idx;
        logic [31:0] wdata;
    } prhc_bus_req_t;

    // pin and analog-side inputs
    typedef struct packed {
        logic ref_choice;
        logic lock_detect;
        logic sync_hold;
        logic ref_a_ok;
        logic ref_b_ok;
        logic pll_locked;
        logic vco_cal_done;
        logic vco_ok;
    } prhc_pins_t;

    typedef enum logic [1:0] {
        PRHC_HO_TRACK,
        PRHC_HO_HOLD
    } prhc_ho_state_t;

    typedef enum logic [1:0] {
        PRHC_BUS_IDLE,
        PRHC_BUS_WAIT
    } prhc_bus_state_t;

endpackage

/* design/prhc_pin_sync.sv */
`timescale 1ns/1ps
module prhc_pin_sync
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire prhc_pkg::prhc_pins_t pins_async,
    output prhc_pkg::prhc_pins_t pins_q
);

    localparam int unsigned NB = $bits(prhc_pkg::prhc_pins_t);

    logic [NB-1:0] ff1_q;
    logic [NB-1:0] ff2_q;
    logic [NB-1:0] ff3_q;
    logic [NB-1:0] out_q;

    assign pins_q = prhc_pkg::prhc_pins_t'(out_q);

    // three stages per bit; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++)
        begin : g_bit
            always_ff @(posedge sys_clk)
            begin
                if (!reset_n)
                begin
                    ff1_q[gi] <= 1'b0;
                    ff2_q[gi] <= 1'b0;
                    ff3_q[gi] <= 1'b0;
                    out_q[gi] <= 1'b0;
                end
                else
                begin
                    ff1_q[gi] <= pins_async[gi];
                    ff2_q[gi] <= ff1_q[gi];
                    ff3_q[gi] <= ff2_q[gi];
                    if (ff2_q[gi] == ff3_q[gi])
                    begin
                        out_q[gi] <= ff3_q[gi];
                    end
                end
            end
        end
    endgenerate

endmodule // prhc_pin_sync

/* design/prhc_ahb_slave.sv */
`timescale 1ns/1ps
module prhc_ahb_slave
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output prhc_pkg::prhc_bus_req_t req
);

    prhc_pkg::prhc_bus_state_t st_q;
    logic wr_q;
    logic [7:0] idx_q;
    logic hreadyout_q;
    logic hresp_q;

    // word transfers only, so size needs no decode
    wire take = hsel && htrans[1] && hready;
    wire in_wait = (st_q == prhc_pkg::PRHC_BUS_WAIT);
    wire unused_size = ^hsize;

    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign req.rd = in_wait && !wr_q;
    assign req.wr = in_wait && wr_q;
    assign req.idx = idx_q;
    assign req.wdata = hwdata;

    // one wait state: access acts in it, ready returns on the next edge
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            st_q <= prhc_pkg::PRHC_BUS_IDLE;
            wr_q <= 1'b0;
            idx_q <= 8'h00;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                prhc_pkg::PRHC_BUS_IDLE:
                begin
                    if (take)
                    begin
                        st_q <= prhc_pkg::PRHC_BUS_WAIT;
                        wr_q <= hwrite;
                        idx_q <= haddr[9:2];
                        hreadyout_q <= 1'b0;
                    end
                end
                prhc_pkg::PRHC_BUS_WAIT:
                begin
                    st_q <= prhc_pkg::PRHC_BUS_IDLE;
                    hreadyout_q <= 1'b1;
                end
                default:
                begin
                    st_q <= prhc_pkg::PRHC_BUS_IDLE;
                    hreadyout_q <= 1'b1;
                end
            endcase
            hresp_q <= 1'b0;
        end
    end

endmodule // prhc_ahb_slave

/* design/prhc_top.sv */
`timescale 1ns/1ps
`include "prhc_regs.svh"
module prhc_top
(
    input wire logic sys_clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pins and analog status, asynchronous
    input wire logic ref_choice_pin,
    input wire logic lock_detect_pin,
    input wire logic sync_hold_pin,
    input wire logic ref_a_ok,
    input wire logic ref_b_ok,
    input wire logic pll_locked,
    input wire logic vco_cal_done,
    input wire logic vco_ok,
    // controls to the analog side
    output logic ref_b_select,
    output logic ref_mute,
    output logic ref_a_pwr_en,
    output logic ref_b_pwr_en,
    output logic ref_diff_mode,
    output logic deglitch_en,
    output logic ld_cmp_en,
    output logic holdover_active,
    output logic irq
);

    localparam logic [3:0] DG_CYC = 4'(`PRHC_DEGLITCH_CYC);

    prhc_pkg::prhc_bus_req_t req;
    prhc_pkg::prhc_pins_t pins_async;
    prhc_pkg::prhc_pins_t pins;
    prhc_pkg::prhc_ho_state_t ho_q;
    prhc_pkg::prhc_ho_state_t ho_d;

    logic [7:0] ref_ctl_q;
    logic [7:0] hold_ctl_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [31:0] hrdata_q;
    logic cur_sel_q;
    logic mute_q;
    logic [3:0] dg_cnt_q;
    logic locked_prev_q;
    logic irq_q;
    logic dg_en_q;
    logic ho_act_q;

    // bus slave with one wait state
    prhc_ahb_slave u_bus
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .req(req)
    );

    // gather the asynchronous inputs
    assign pins_async.ref_choice = ref_choice_pin;
    assign pins_async.lock_detect = lock_detect_pin;
    assign pins_async.sync_hold = sync_hold_pin;
    assign pins_async.ref_a_ok = ref_a_ok;
    assign pins_async.ref_b_ok = ref_b_ok;
    assign pins_async.pll_locked = pll_locked;
    assign pins_async.vco_cal_done = vco_cal_done;
    assign pins_async.vco_ok = vco_ok;

    // three-stage synchronisers for every pin
    prhc_pin_sync u_sync
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pins_async(pins_async),
        .pins_q(pins)
    );

    // register decode
    wire wr_ref = req.wr && (req.idx == `PRHC_IDX_REF_CTRL);
    wire wr_hold = req.wr && (req.idx == `PRHC_IDX_HOLD_CTRL);
    wire wr_mask = req.wr && (req.idx == `PRHC_IDX_IRQ_MASK);
    wire rd_irq = req.rd && (req.idx == `PRHC_IDX_IRQ_STAT);

    // reference control fields; bits 4:3 are never stored
    wire dg_dis = ref_ctl_q[`PRHC_REF_DEGLITCH_DIS];
    wire sel_b_bit = ref_ctl_q[`PRHC_REF_SEL_B];
    wire use_pin = ref_ctl_q[`PRHC_REF_USE_PIN];
    wire diff = ref_ctl_q[`PRHC_REF_DIFF];

    // holdover control fields
    wire stat_dis = hold_ctl_q[`PRHC_HOLD_STAT_DIS];
    wire cmp_en = hold_ctl_q[`PRHC_HOLD_CMP_EN];
    wire ext_hold = hold_ctl_q[`PRHC_HOLD_EXT];
    wire hold_en = hold_ctl_q[`PRHC_HOLD_EN_HI] && hold_ctl_q[`PRHC_HOLD_EN_LO];

    // requested reference; differential mode only has the a input
    wire pin_or_reg = use_pin ? pins.ref_choice : sel_b_bit;
    wire req_sel = pin_or_reg && !diff;
    wire sel_change = (req_sel != cur_sel_q);

    // lock judgement; a disabled comparator counts as true
    wire lock_ok = cmp_en ? pins.lock_detect : 1'b1;
    wire sel_ref_ok = cur_sel_q ? pins.ref_b_ok : pins.ref_a_ok;

    // status words
    wire [7:0] pll_stat = {1'b0,
                           pins.vco_cal_done,
                           (ho_q == prhc_pkg::PRHC_HO_HOLD),
                           cur_sel_q,
                           pins.vco_ok,
                           pins.ref_b_ok,
                           pins.ref_a_ok,
                           pins.pll_locked};
    wire [7:0] pll_stat_rd = stat_dis ? 8'h00 : pll_stat;

    // read mux; unmapped words read zero
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (req.idx)
            `PRHC_IDX_REF_CTRL: rd_mux = {24'h00_0000, ref_ctl_q};
            `PRHC_IDX_HOLD_CTRL: rd_mux = {24'h00_0000, hold_ctl_q};
            `PRHC_IDX_PLL_STAT: rd_mux = {24'h00_0000, pll_stat_rd};
            `PRHC_IDX_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_q};
            `PRHC_IDX_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is captured in the wait state
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            hrdata_q <= 32'h0000_0000;
        end
        else if (req.rd)
        begin
            hrdata_q <= rd_mux;
        end
    end

    // control registers hold until rewritten
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ref_ctl_q <= `PRHC_REF_RESET;
            dg_en_q <= 1'b1; // deglitch on while bit7 resets to zero
            hold_ctl_q <= `PRHC_HOLD_RESET;
            irq_mask_q <= `PRHC_IRQ_RESET;
        end
        else
        begin
            if (wr_ref)
            begin
                ref_ctl_q <= req.wdata[7:0] & `PRHC_REF_WMASK;
                dg_en_q <= !req.wdata[`PRHC_REF_DEGLITCH_DIS];
            end
            if (wr_hold)
            begin
                hold_ctl_q <= req.wdata[7:0] & `PRHC_HOLD_WMASK;
            end
            if (wr_mask)
            begin
                irq_mask_q <= req.wdata[3:0];
            end
        end
    end

    // reference switch; deglitch mutes the reference for a gap first
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cur_sel_q <= 1'b0;
            mute_q <= 1'b0;
            dg_cnt_q <= 4'h0;
        end
        else if (!sel_change)
        begin
            mute_q <= 1'b0;
            dg_cnt_q <= 4'h0;
        end
        else if (dg_dis || (dg_cnt_q == DG_CYC))
        begin
            cur_sel_q <= req_sel;
            mute_q <= 1'b0;
            dg_cnt_q <= 4'h0;
        end
        else
        begin
            mute_q <= 1'b1;
            dg_cnt_q <= dg_cnt_q + 4'h1;
        end
    end

    // holdover next state
    always_comb
    begin
        ho_d = ho_q;
        case (ho_q)
            prhc_pkg::PRHC_HO_TRACK:
            begin
                if (hold_en && ext_hold && pins.sync_hold)
                begin
                    ho_d = prhc_pkg::PRHC_HO_HOLD;
                end
                else if (hold_en && !ext_hold && !sel_ref_ok && lock_ok)
                begin
                    ho_d = prhc_pkg::PRHC_HO_HOLD;
                end
            end
            prhc_pkg::PRHC_HO_HOLD:
            begin
                if (!hold_en)
                begin
                    ho_d = prhc_pkg::PRHC_HO_TRACK;
                end
                else if (ext_hold && !pins.sync_hold)
                begin
                    ho_d = prhc_pkg::PRHC_HO_TRACK;
                end
                else if (!ext_hold && sel_ref_ok)
                begin
                    ho_d = prhc_pkg::PRHC_HO_TRACK;
                end
            end
            default:
            begin
                ho_d = prhc_pkg::PRHC_HO_TRACK;
            end
        endcase
    end

    // holdover state
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ho_q <= prhc_pkg::PRHC_HO_TRACK;
            ho_act_q <= 1'b0;
        end
        else
        begin
            ho_q <= ho_d;
            ho_act_q <= (ho_d == prhc_pkg::PRHC_HO_HOLD);
        end
    end

    // event detection
    wire ev_in = (ho_q == prhc_pkg::PRHC_HO_TRACK) && (ho_d == prhc_pkg::PRHC_HO_HOLD);
    wire ev_out = (ho_q == prhc_pkg::PRHC_HO_HOLD) && (ho_d == prhc_pkg::PRHC_HO_TRACK);
    wire ev_sw = sel_change && (dg_dis || (dg_cnt_q == DG_CYC));
    wire ev_lost = locked_prev_q && !pins.pll_locked;
    wire [3:0] ev_vec = {ev_lost, ev_sw, ev_out, ev_in};

    // sticky status, cleared by reading; a new event beats the clear
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            irq_stat_q <= `PRHC_IRQ_RESET;
            locked_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (rd_irq ? 4'h0 : irq_stat_q) | ev_vec;
            locked_prev_q <= pins.pll_locked;
            irq_q <= |(((rd_irq ? 4'h0 : irq_stat_q) | ev_vec) & irq_mask_q);
        end
    end

    // registered outputs
    assign hrdata = hrdata_q;
    assign ref_b_select = cur_sel_q;
    assign ref_mute = mute_q;
    assign ref_a_pwr_en = ref_ctl_q[`PRHC_REF_A_PWR];
    assign ref_b_pwr_en = ref_ctl_q[`PRHC_REF_B_PWR];
    assign ref_diff_mode = diff;
    assign deglitch_en = dg_en_q;
    assign ld_cmp_en = cmp_en;
    assign holdover_active = ho_act_q;
    assign irq = irq_q;

endmodule // prhc_top

/* testbench/prhc_top_sva.sv */
`timescale 1ns/1ps
`include "prhc_regs.svh"
module prhc_chk
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic sync_hold_pin,
    input wire logic ref_b_select,
    input wire logic ref_mute,
    input wire logic ref_a_pwr_en,
    input wire logic ref_b_pwr_en,
    input wire logic ref_diff_mode,
    input wire logic deglitch_en,
    input wire logic ld_cmp_en,
    input wire logic holdover_active
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // data phase tracking and shadows of both control registers
    logic dp_q;
    logic w_q;
    logic [31:0] a_q;
    logic [7:0] ref_q;
    logic [7:0] hold_q;
    wire take = hsel & htrans[1] & hready;
    wire done_w = dp_q & hready & w_q;
    wire wr_ref = done_w & (a_q == {22'h0, `PRHC_IDX_REF_CTRL, 2'b00});
    wire wr_hold = done_w & (a_q == {22'h0, `PRHC_IDX_HOLD_CTRL, 2'b00});
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            dp_q <= 1'b0;
            ref_q <= 8'h00;
            hold_q <= 8'h00;
        end
        else
        begin
            dp_q <= hready ? take : dp_q;
            a_q <= take ? haddr : a_q;
            w_q <= take ? hwrite : w_q;
            ref_q <= wr_ref ? (hwdata[7:0] & `PRHC_REF_WMASK) : ref_q;
            hold_q <= wr_hold ? (hwdata[7:0] & `PRHC_HOLD_WMASK) : hold_q;
        end
    end
    // one wait state, then ready again
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    // shadow settled and no data phase open; the design may apply a write before the data phase ends
    sequence s_ref_set;
        $stable(ref_q)[*3] ##0 !dp_q;
    endsequence
    sequence s_hold_set;
        $stable(hold_q)[*3] ##0 !dp_q;
    endsequence
    a_bus_wait: assert property (take |=> s_wait)
        else $error("wait state wrong");
    a_deglitch_map: assert property (s_ref_set |-> deglitch_en == !ref_q[7])
        else $error("deglitch enable wrong");
    a_pwr_b_map: assert property (s_ref_set |-> ref_b_pwr_en == ref_q[2])
        else $error("b power wrong");
    a_pwr_a_map: assert property (s_ref_set |-> ref_a_pwr_en == ref_q[1])
        else $error("a power wrong");
    a_diff_map: assert property (s_ref_set |-> ref_diff_mode == ref_q[0])
        else $error("diff mode wrong");
    a_cmp_map: assert property (s_hold_set |-> ld_cmp_en == hold_q[3])
        else $error("comparator enable wrong");
    a_reg_select: assert property ((ref_q[7] & !ref_q[5] & !ref_q[0] & $stable(ref_q))[*4] |-> ref_b_select == ref_q[6])
        else $error("register select wrong");
    a_hold_gated: assert property ((!(hold_q[2] & hold_q[0]))[*4] |-> !holdover_active)
        else $error("holdover while disabled");
    a_ext_hold: assert property ((hold_q[2:0] == 3'h7 && sync_hold_pin)[*8] |-> holdover_active)
        else $error("sync pin holdover missing");
    a_mute_gap: assert property ($changed(ref_b_select) && !ref_q[7] && $stable(ref_q) |-> $past(ref_mute))
        else $error("switch without mute");
endmodule // prhc_chk

/* testbench/testbench.sv */
`timescale 1ns/1ps
`include "prhc_regs.svh"
module testbench;
    localparam logic [31:0] A_REF = {22'h0, `PRHC_IDX_REF_CTRL, 2'b00};
    localparam logic [31:0] A_HOLD = {22'h0, `PRHC_IDX_HOLD_CTRL, 2'b00};
    localparam logic [31:0] A_STAT = {22'h0, `PRHC_IDX_PLL_STAT, 2'b00};
    localparam logic [31:0] A_IRQ = {22'h0, `PRHC_IDX_IRQ_STAT, 2'b00};
    localparam logic [31:0] A_MASK = {22'h0, `PRHC_IDX_IRQ_MASK, 2'b00};
    localparam logic [31:0] A_GAP = 32'h78;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    // vco_ok, cal_done, locked, b_ok, a_ok, sync_hold, lock_detect, ref_choice
    logic [7:0] pins = 8'hb8;
    logic chk_stb = 1'b0;
    logic rd_dp = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int n_errors = 0;
    int compares = 0;
    wire hreadyout;
    wire [31:0] hrdata;
    wire [9:0] obs;
    wire [10:0] mon = {hreadyout, obs};

    always #2 sys_clk = ~sys_clk;

    prhc_top u_dut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp(obs[0]), .hrdata, .ref_choice_pin(pins[0]),
        .lock_detect_pin(pins[1]), .sync_hold_pin(pins[2]), .ref_a_ok(pins[3]), .ref_b_ok(pins[4]),
        .pll_locked(pins[5]), .vco_cal_done(pins[6]), .vco_ok(pins[7]), .ref_b_select(obs[1]),
        .ref_mute(obs[2]), .ref_a_pwr_en(obs[3]), .ref_b_pwr_en(obs[4]), .ref_diff_mode(obs[5]),
        .deglitch_en(obs[6]), .ld_cmp_en(obs[7]), .holdover_active(obs[8]), .irq(obs[9]));

    task automatic tally_and_finish;
        if (n_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // bounded wait for one monitored output to be high
    task automatic wait_bit(input int b);
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (mon[b] !== 1'b1 && n < 40);
        if (mon[b] !== 1'b1)
        begin
            n_errors++;
            tally_and_finish;
        end
    endtask

    // one single transfer; a read notes its expected word and mask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_bit(10);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!w)
        begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        wait_bit(10);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, 32'h0);
    endtask

    // notes an expected output pattern and asks the monitor to look
    task automatic see(input logic [9:0] m, input logic [9:0] v);
        exp_q.push_back({22'h0, v});
        msk_q.push_back({22'h0, m});
        chk_stb <= 1'b1;
        cyc(1);
        chk_stb <= 1'b0;
        cyc(1);
    endtask

    // takes the oldest note whenever a result shows at the ports
    always @(posedge sys_clk)
    begin
        logic [31:0] got;
        logic [31:0] e;
        logic [31:0] m;
        if ((rd_dp && hreadyout === 1'b1) || chk_stb)
        begin
            got = chk_stb ? {22'h0, obs} : hrdata;
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            compares++;
            if ((got & m) !== (e & m))
            begin
                n_errors++;
                $display("MISMATCH time=%0t got=%h exp=%h", $time, got & m, e & m);
            end
        end
        if (hreadyout === 1'b1)
            rd_dp <= hsel & htrans[1] & !hwrite;
    end

    initial
    begin
        logic [7:0] r;
        logic [7:0] h;
        void'($urandom(30));
        cyc(3);
        reset_n <= 1'b1;
        cyc(5);
        see(10'h3ff, 10'h040);
        ahb(1'b0, A_REF, 32'h0, ALL);
        ahb(1'b0, A_HOLD, 32'h0, ALL);
        // random control words, unmapped access, pin copies
        repeat (6)
        begin
            r = 8'($urandom);
            h = 8'($urandom);
            h[0] = h[0] & h[1];
            wr(A_REF, {24'h0, r});
            wr(A_HOLD, {24'h0, h});
            wr(A_GAP, ALL);
            ahb(1'b0, A_REF, {24'h0, r & 8'he7}, ALL);
            ahb(1'b0, A_HOLD, {24'h0, h & 8'h1f}, ALL);
            ahb(1'b0, A_STAT, 32'h0, h[4] ? ALL : 32'h0);
            ahb(1'b0, A_GAP, 32'h0, ALL);
            see(10'h0f8, {2'h0, h[3], !r[7], r[0], r[2], r[1], 3'h0});
        end
        // selection by register, by pin, differential, then with deglitch gap
        wr(A_HOLD, 32'h10);
        ahb(1'b0, A_STAT, 32'h0, ALL);
        wr(A_HOLD, 32'h0);
        wr(A_REF, 32'hc6);
        cyc(2);
        see(10'h006, 10'h002);
        ahb(1'b0, A_STAT, 32'h1f, ALL);
        wr(A_REF, 32'ha6);
        cyc(3);
        see(10'h006, 10'h000);
        wr(A_REF, 32'ha7);
        pins[0] <= 1'b1;
        cyc(10);
        see(10'h026, 10'h020);
        wr(A_REF, 32'h26);
        wait_bit(2);
        see(10'h006, 10'h004);
        cyc(6);
        see(10'h006, 10'h002);
        // automatic holdover with interrupt masked, unmasked and cleared
        wr(A_REF, 32'h86);
        pins[6] <= 1'b1;
        wr(A_HOLD, 32'h05);
        ahb(1'b0, A_IRQ, 32'h0, 32'h0);
        pins[3] <= 1'b0;
        cyc(10);
        see(10'h300, 10'h100);
        ahb(1'b0, A_STAT, 32'h6d, ALL);
        wr(A_MASK, 32'h1);
        see(10'h200, 10'h200);
        ahb(1'b0, A_IRQ, 32'h1, ALL);
        cyc(2);
        see(10'h200, 10'h000);
        pins[3] <= 1'b1;
        cyc(10);
        see(10'h100, 10'h000);
        ahb(1'b0, A_IRQ, 32'h2, ALL);
        // comparator gates entry on the lock pin
        wr(A_HOLD, 32'h0d);
        pins[3] <= 1'b0;
        cyc(10);
        see(10'h180, 10'h080);
        pins[1] <= 1'b1;
        cyc(10);
        see(10'h100, 10'h100);
        wr(A_HOLD, 32'h04);
        cyc(3);
        see(10'h100, 10'h000);
        // external holdover through the sync pin
        wr(A_HOLD, 32'h07);
        pins[2] <= 1'b1;
        cyc(10);
        see(10'h100, 10'h100);
        pins[2] <= 1'b0;
        cyc(10);
        see(10'h100, 10'h000);
        tally_and_finish;
    end
endmodule // testbench

bind prhc_top prhc_chk u_chk (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .sync_hold_pin, .ref_b_select, .ref_mute, .ref_a_pwr_en, .ref_b_pwr_en, .ref_diff_mode,
    .deglitch_en, .ld_cmp_en, .holdover_active);
